// [ctl_input_map.svh]
// Register offsets, field positions and reset values of the input block
`ifndef CTL_INPUT_MAP_SVH
`define CTL_INPUT_MAP_SVH

`define CTL_ADDR_W          8
`define CTL_OFF_STATUS      8'h00
`define CTL_OFF_LATCH_EN    8'h04
`define CTL_OFF_LATCH_RST   8'h08
`define CTL_OFF_GATE        8'h0c
`define CTL_OFF_POLARITY    8'h14
`define CTL_OFF_RISE        8'h18
`define CTL_OFF_FALL        8'h1c
`define CTL_OFF_BUFFER      8'h20

`define CTL_IN_LSB          0
`define CTL_IN_MSB          1
`define CTL_OVR_BIT         8
`define CTL_STAT_PIN_LSB    0
`define CTL_STAT_PIN_MSB    1
`define CTL_STAT_ASRT_LSB   2
`define CTL_STAT_ASRT_MSB   3
`define CTL_STAT_OVR_BIT    4

`define CTL_POLARITY_RESET  2'h0
`define CTL_BUFFER_RESET    2'h0
`define CTL_FLAG_RESET      2'h0
`define CTL_LATCH_EN_RESET  2'h0
`define CTL_GATE_RESET      2'h3
`define CTL_OVR_GATE_RESET  1'h1
`define CTL_OVR_BUF_RESET   1'h0

`endif

// [ctl_input_pkg.sv]
// Bus carrier and output types of the input conditioning block
`default_nettype none
package ctl_input_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic [1:0] control_input_asserted;
    logic [1:0] control_input_buffer_on;
    logic       override_asserted;
    logic       override_buffer_on;
  } cond_out_type;
endpackage
`default_nettype wire

// [edge_flag.sv]
// One sticky edge flag with write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module edge_flag #(
  parameter bit RISE = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Detection
  input  wire logic enable,
  input  wire logic level,
  input  wire logic last_level,
  // Software clear
  input  wire logic clear,
  // Sticky flag
  output logic      flag
);
  logic seen;

  assign seen = enable & (RISE ? (level & ~last_level)
                               : (~level & last_level));

  // A new edge in the clearing cycle keeps the flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= seen | (flag & ~clear);
    end
  end
endmodule // edge_flag
`default_nettype wire

// [ctl_input_cond.sv]
// Polarity, gating, edge capture and latching of the control inputs
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ctl_input_map.svh"
module ctl_input_cond (
  // Clock and reset
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  // APB slave
  input  wire ctl_input_pkg::apb_req_type APB_REQ,
  output ctl_input_pkg::apb_rsp_type      APB_RSP,
  // Input pins
  input  wire logic [1:0]                CONTROL_INPUT_PINS,
  input  wire logic                      OVERRIDE_INPUT_PIN,
  // Conditioned signals towards the output logic
  output ctl_input_pkg::cond_out_type     COND_OUT
);
  import ctl_input_pkg::*;

  logic [1:0]  control_input_polarity;
  logic [1:0]  control_input_buffer_on;
  logic [1:0]  control_input_gate_bits;
  logic [1:0]  latch_enable;
  logic        override_buffer_on;
  logic        override_input_gate;
  logic [1:0]  control_input_rise_flag;
  logic [1:0]  control_input_fall_flag;
  logic [1:0]  pin_last;
  logic [1:0]  latch_held;
  logic [1:0]  asserted_now;
  logic [1:0]  asserted_gated;
  logic [1:0]  edge_enable;
  logic [1:0]  latch_reset;
  logic        setup;
  logic        access;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_word;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] wd;
  logic [7:0]  ad;

  assign ad     = APB_REQ.paddr;
  assign wd     = APB_REQ.pwdata;
  assign setup  = APB_REQ.psel & ~APB_REQ.penable;
  assign access = APB_REQ.psel & APB_REQ.penable;
  assign wr     = access & APB_REQ.pwrite;

  // Pin level after polarity: one means asserted
  assign asserted_now   = ~(CONTROL_INPUT_PINS ^ control_input_polarity);
  assign asserted_gated = asserted_now & control_input_gate_bits;
  // Buffer bit overrides the gate for edge capture
  assign edge_enable    = control_input_buffer_on | control_input_gate_bits;
  assign latch_reset    = (wr && ad == `CTL_OFF_LATCH_RST) ?
                          wd[`CTL_IN_MSB:`CTL_IN_LSB] : 2'h0;

  always_comb begin
    mapped = 1'b1;
    rd_word = 32'h0;
    case (ad)
      `CTL_OFF_STATUS: begin
        rd_word[`CTL_STAT_PIN_MSB:`CTL_STAT_PIN_LSB] = CONTROL_INPUT_PINS;
        rd_word[`CTL_STAT_ASRT_MSB:`CTL_STAT_ASRT_LSB] =
          COND_OUT.control_input_asserted;
        rd_word[`CTL_STAT_OVR_BIT] = OVERRIDE_INPUT_PIN;
      end
      `CTL_OFF_LATCH_EN: begin
        rd_word[`CTL_IN_MSB:`CTL_IN_LSB] = latch_enable;
      end
      `CTL_OFF_LATCH_RST: begin
        rd_word = 32'h0;
      end
      `CTL_OFF_GATE: begin
        rd_word[`CTL_IN_MSB:`CTL_IN_LSB] = control_input_gate_bits;
        rd_word[`CTL_OVR_BIT] = override_input_gate;
      end
      `CTL_OFF_POLARITY: begin
        rd_word[`CTL_IN_MSB:`CTL_IN_LSB] = control_input_polarity;
      end
      `CTL_OFF_RISE: begin
        rd_word[`CTL_IN_MSB:`CTL_IN_LSB] = control_input_rise_flag;
      end
      `CTL_OFF_FALL: begin
        rd_word[`CTL_IN_MSB:`CTL_IN_LSB] = control_input_fall_flag;
      end
      `CTL_OFF_BUFFER: begin
        rd_word[`CTL_IN_MSB:`CTL_IN_LSB] = control_input_buffer_on;
        rd_word[`CTL_OVR_BIT] = override_buffer_on;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle, so the slave
  // can answer with no wait state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= APB_REQ.pwrite ? 32'h0 : rd_word;
      pslverr <= ~mapped;
    end
  end

  always_comb begin
    APB_RSP.prdata  = prdata;
    APB_RSP.pready  = 1'b1;
    APB_RSP.pslverr = access & pslverr;
  end

  // Control registers, reset only by the battery-domain reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      control_input_polarity <= `CTL_POLARITY_RESET;
    end else if (wr && ad == `CTL_OFF_POLARITY) begin
      control_input_polarity <= wd[`CTL_IN_MSB:`CTL_IN_LSB];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      control_input_buffer_on <= `CTL_BUFFER_RESET;
      override_buffer_on      <= `CTL_OVR_BUF_RESET;
    end else if (wr && ad == `CTL_OFF_BUFFER) begin
      control_input_buffer_on <= wd[`CTL_IN_MSB:`CTL_IN_LSB];
      override_buffer_on      <= wd[`CTL_OVR_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      control_input_gate_bits <= `CTL_GATE_RESET;
      override_input_gate     <= `CTL_OVR_GATE_RESET;
    end else if (wr && ad == `CTL_OFF_GATE) begin
      control_input_gate_bits <= wd[`CTL_IN_MSB:`CTL_IN_LSB];
      override_input_gate     <= wd[`CTL_OVR_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_enable <= `CTL_LATCH_EN_RESET;
    end else if (wr && ad == `CTL_OFF_LATCH_EN) begin
      latch_enable <= wd[`CTL_IN_MSB:`CTL_IN_LSB];
    end
  end

  // Previous pin sample for edge detection; it follows the pins even in
  // reset, since a constant reset value would fake an edge on release
  always_ff @(posedge CLK) begin
    pin_last <= CONTROL_INPUT_PINS;
  end

  // Latch: an asserted input outranks a reset write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_held <= 2'h0;
    end else begin
      latch_held <= latch_enable &
                    (asserted_gated | (latch_held & ~latch_reset));
    end
  end

  // Outputs to the output-drive logic
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      COND_OUT <= '0;
    end else begin
      COND_OUT.control_input_asserted  <= asserted_gated | latch_held;
      COND_OUT.control_input_buffer_on <= edge_enable;
      COND_OUT.override_asserted  <= OVERRIDE_INPUT_PIN &
                                     override_input_gate;
      COND_OUT.override_buffer_on <= override_buffer_on |
                                     override_input_gate;
    end
  end

  // Rise and fall flags work on the raw pin, ahead of polarity
  for (genvar i = 0; i < 2; i++) begin : g_flag
    edge_flag #(.RISE(1'b1)) u_rise (
      .clk        (CLK),
      .rst_n      (RST_N),
      .enable     (edge_enable[i]),
      .level      (CONTROL_INPUT_PINS[i]),
      .last_level (pin_last[i]),
      .clear      (wr && ad == `CTL_OFF_RISE && wd[i]),
      .flag       (control_input_rise_flag[i])
    );
    edge_flag #(.RISE(1'b0)) u_fall (
      .clk        (CLK),
      .rst_n      (RST_N),
      .enable     (edge_enable[i]),
      .level      (CONTROL_INPUT_PINS[i]),
      .last_level (pin_last[i]),
      .clear      (wr && ad == `CTL_OFF_FALL && wd[i]),
      .flag       (control_input_fall_flag[i])
    );
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_pol_reset: assert property (
    @(posedge CLK) disable iff (1'b0)
    !RST_N |=> control_input_polarity == 2'h0)
    else $error("polarity not cleared by reset");
  a_rise_set: assert property (
    (edge_enable[0] && CONTROL_INPUT_PINS[0] && !pin_last[0])
    |=> control_input_rise_flag[0])
    else $error("rising edge not captured");
  a_fall_set: assert property (
    (edge_enable[1] && !CONTROL_INPUT_PINS[1] && pin_last[1])
    |=> control_input_fall_flag[1])
    else $error("falling edge not captured");
  a_gated_hold: assert property (
    (!control_input_buffer_on[0] && !control_input_gate_bits[0] &&
     !control_input_rise_flag[0]) |=> !control_input_rise_flag[0])
    else $error("gated input set a flag");
  a_buffer_force: assert property (
    control_input_buffer_on[1] |=>
    COND_OUT.control_input_buffer_on[1])
    else $error("buffer bit did not force buffer");
  a_ovr_buffer: assert property (
    override_buffer_on |=> COND_OUT.override_buffer_on)
    else $error("override buffer not forced");
  a_w1c_clear: assert property (
    (wr && ad == `CTL_OFF_FALL && wd[0] &&
     !(edge_enable[0] && pin_last[0] && !CONTROL_INPUT_PINS[0]))
    |=> !control_input_fall_flag[0])
    else $error("fall flag not cleared");
  a_set_wins: assert property (
    (wr && ad == `CTL_OFF_RISE && wd[0] && edge_enable[0] &&
     CONTROL_INPUT_PINS[0] && !pin_last[0])
    |=> control_input_rise_flag[0])
    else $error("edge lost during clear");
  a_polarity_map: assert property (
    (!latch_enable[0] && !latch_held[0]) |=>
    COND_OUT.control_input_asserted[0] ==
    $past(~(CONTROL_INPUT_PINS[0] ^ control_input_polarity[0]) &
          control_input_gate_bits[0]))
    else $error("asserted level does not follow polarity");
  a_latch_priority: assert property (
    (latch_enable[0] && asserted_gated[0] && latch_reset[0])
    |=> latch_held[0] ##1 COND_OUT.control_input_asserted[0])
    else $error("latch reset beat an asserted input");
endmodule // ctl_input_cond
`default_nettype wire

// [switch_model.sv]
// Model of the switches and system signals on the input pins
`timescale 1ns/1ps
`default_nettype none
module switch_model (
  // Clock
  input  wire logic       CLK,
  // Levels requested by the bench
  input  wire logic [1:0] LEVEL_REQ,
  input  wire logic       OVR_REQ,
  // Pins
  output logic [1:0]      CONTROL_INPUT_PINS,
  output logic            OVERRIDE_INPUT_PIN
);
  // Clean switches: the level moves only on a clock edge, never bounces
  always_ff @(posedge CLK) begin
    CONTROL_INPUT_PINS <= LEVEL_REQ;
    OVERRIDE_INPUT_PIN <= OVR_REQ;
  end
endmodule // switch_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the input conditioning block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ctl_input_pkg::*;
  logic         clk;
  logic         rst_n;
  logic [1:0]   lvl;
  logic         ovr_req;
  logic [1:0]   pins;
  logic         ovr_pin;
  apb_req_type  req;
  apb_rsp_type  rsp;
  cond_out_type cond;
  logic [31:0]  rd;
  logic         err;
  int           fails;
  int           cmp_count;

  ctl_input_cond u_dut (.CLK(clk), .RST_N(rst_n), .APB_REQ(req),
    .APB_RSP(rsp), .CONTROL_INPUT_PINS(pins),
    .OVERRIDE_INPUT_PIN(ovr_pin), .COND_OUT(cond));
  switch_model u_sw (.CLK(clk), .LEVEL_REQ(lvl), .OVR_REQ(ovr_req),
    .CONTROL_INPUT_PINS(pins), .OVERRIDE_INPUT_PIN(ovr_pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    // Wait for pready rather than assume the slave's latency
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Edge capture lags the pin by a few cycles through two registers
  task automatic pin(input logic [1:0] l);
    lvl <= l;
    repeat (4) @(posedge clk);
  endtask

  task final_report;
    $display("Compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    final_report;
  end

  initial begin
    req = '0;
    rst_n = 1'b0;
    lvl = 2'b11;
    ovr_req = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(8'h14, 32'h0);
    rchk(8'h18, 32'h0);
    rchk(8'h1c, 32'h0);
    rchk(8'h20, 32'h0);
    rchk(8'h0c, 32'h103);
    pin(2'b10);
    rchk(8'h00, 32'h6);
    rchk(8'h1c, 32'h1);
    apb(1'b1, 8'h14, 32'h3);
    rchk(8'h00, 32'ha);
    pin(2'b11);
    rchk(8'h18, 32'h1);
    apb(1'b1, 8'h18, 32'h1);
    rchk(8'h18, 32'h0);
    apb(1'b1, 8'h1c, 32'h0);
    rchk(8'h1c, 32'h1);
    apb(1'b1, 8'h1c, 32'h3);
    apb(1'b1, 8'h0c, 32'h0);
    pin(2'b00);
    rchk(8'h1c, 32'h0);
    chk(32'(cond.control_input_buffer_on), 32'h0);
    apb(1'b1, 8'h20, 32'h103);
    pin(2'b11);
    rchk(8'h18, 32'h3);
    chk(32'(cond.control_input_buffer_on), 32'h3);
    chk(32'(cond.override_buffer_on), 32'h1);
    apb(1'b1, 8'h20, 32'h0);
    apb(1'b1, 8'h18, 32'h3);
    apb(1'b1, 8'h08, 32'h3);
    chk(32'(cond.override_buffer_on), 32'h0);
    rchk(8'h18, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h0c, 32'h103);
    apb(1'b1, 8'h14, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    pin(2'b10);
    apb(1'b1, 8'h08, 32'h1);
    pin(2'b11);
    rchk(8'h00, 32'h7);
    apb(1'b1, 8'h08, 32'h1);
    rchk(8'h00, 32'h3);
    ovr_req <= 1'b1;
    pin(2'b11);
    chk(32'(cond.override_asserted), 32'h1);
    rchk(8'h00, 32'h13);
    apb(1'b1, 8'h0c, 32'h3);
    pin(2'b11);
    chk(32'(cond.override_asserted), 32'h0);
    chk(32'(cond.override_buffer_on), 32'h0);
    final_report;
  end
endmodule // tb_top
`default_nettype wire
